// *** logic/dpsa_arbiter.sv ***
// Three-wire serial port and first-come arbiter against a single-wire port.
// Assumes pins arrive asynchronous to clock; memory sits outside behind a byte port.
`timescale 1ns/1ps
`default_nettype none
`include "dpsa_consts.svh"
module dpsa_arbiter (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic selectPin,
  input wire logic serialClockPin,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOutEnable,
  input wire logic singleWireIn,
  output logic singleWireOutEnable,
  input wire logic supplyMarginOk,
  input wire logic oscillatorRunning,
  input wire logic threeWireOnly,
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxFirst,
  input wire logic [7:0] txByte,
  input wire logic txReading,
  output logic txByteTaken,
  output logic transferEnd,
  output logic [1:0] grant,
  output logic accessAllowed,
  output logic singleWireGranted,
  output logic singleWireDenied,
  output logic eventCountPulse
);
  // ************************************************
  // Synchronisers
  // ************************************************
  logic [1:0] selSync, sclkSync, swSync;
  logic selQ, sclkQ, swQ;
  always_ff @(posedge clock) begin
    if (reset) begin
      selSync <= 2'h0;
      sclkSync <= 2'h0;
      swSync <= 2'h3;
      selQ <= 1'b0;
      sclkQ <= 1'b0;
      swQ <= 1'b1;
    end else if (clockEnable) begin
      selSync <= {selSync[0], selectPin};
      sclkSync <= {sclkSync[0], serialClockPin};
      swSync <= {swSync[0], singleWireIn};
      selQ <= selSync[1];
      sclkQ <= sclkSync[1];
      swQ <= swSync[1];
    end
  end
  logic sel, sclk, sw, dqIn;
  assign sel = selSync[1];
  assign sclk = sclkSync[1];
  assign sw = swSync[1];
  logic [1:0] dqSync;
  always_ff @(posedge clock) begin
    if (reset) dqSync <= 2'h0;
    else if (clockEnable) dqSync <= {dqSync[0], dataIn};
  end
  assign dqIn = dqSync[1];
  logic selRise, selFall, sclkRise, sclkFall, swFall, swRise;
  assign selRise = sel & ~selQ;
  assign selFall = ~sel & selQ;
  assign sclkRise = sclk & ~sclkQ;
  assign sclkFall = ~sclk & sclkQ;
  assign swFall = ~sw & swQ;
  assign swRise = sw & ~swQ;

  // ************************************************
  // Supply gate and settle timer
  // ************************************************
  logic [`DPSA_CNT_W-1:0] settleCount;
  logic settled;
  always_ff @(posedge clock) begin
    if (reset) begin
      settleCount <= '0;
      settled <= 1'b0;
    end else if (clockEnable) begin
      if (!supplyMarginOk) begin
        settleCount <= '0;
        settled <= 1'b0;
      end else if (!oscillatorRunning) begin
        settled <= 1'b1;
      end else if (settleCount == `DPSA_CNT_W'(`DPSA_SETTLE_CYC - 1)) begin
        settled <= 1'b1;
      end else if (!settled) begin
        settleCount <= settleCount + `DPSA_CNT_W'(1);
      end
    end
  end
  // Three-wire port stays locked until one single-wire reset after power-up
  logic swEnabled;
  assign accessAllowed = supplyMarginOk & settled;

  // ************************************************
  // Single-wire reset and presence
  // ************************************************
  dpsa_pkg::dpsa_sw_t swState;
  logic [`DPSA_CNT_W-1:0] swCount;
  always_ff @(posedge clock) begin
    if (reset) begin
      swState <= dpsa_pkg::SW_IDLE;
      swCount <= '0;
      swEnabled <= 1'b0;
    end else if (clockEnable) begin
      case (swState)
        dpsa_pkg::SW_PRESENCE: begin
          if (swCount == `DPSA_CNT_W'(`DPSA_PDL_CYC - 1)) begin
            swState <= dpsa_pkg::SW_ARMED;
            swEnabled <= 1'b1;
          end
          swCount <= swCount + `DPSA_CNT_W'(1);
        end
        dpsa_pkg::SW_WAIT_HIGH: begin
          if (swCount == `DPSA_CNT_W'(`DPSA_PDH_CYC - 1)) begin
            swState <= dpsa_pkg::SW_PRESENCE;
            swCount <= '0;
          end else begin
            swCount <= swCount + `DPSA_CNT_W'(1);
          end
        end
        dpsa_pkg::SW_RESET_LOW: begin
          if (swRise) begin
            swState <= (swCount >= `DPSA_CNT_W'(`DPSA_RSTL_CYC)) ? dpsa_pkg::SW_WAIT_HIGH : dpsa_pkg::SW_IDLE;
            swCount <= '0;
          end else if (swCount != {`DPSA_CNT_W{1'b1}}) begin
            swCount <= swCount + `DPSA_CNT_W'(1);
          end
        end
        dpsa_pkg::SW_BUSY: begin
          // Slots keep the exchange alive; only a reset-length low or loss of accessAllowed closes it
          if (swRise) begin
            if (swCount >= `DPSA_CNT_W'(`DPSA_RSTL_CYC)) swState <= dpsa_pkg::SW_WAIT_HIGH;
            swCount <= '0;
          end else if (!sw && swCount != {`DPSA_CNT_W{1'b1}}) begin
            swCount <= swCount + `DPSA_CNT_W'(1);
          end
        end
        default: begin
          // Idle or armed: a fall starts a reset pulse or, once armed, the exchange
          if (swFall) begin
            swState <= (swState == dpsa_pkg::SW_ARMED) ? dpsa_pkg::SW_BUSY : dpsa_pkg::SW_RESET_LOW;
            swCount <= '0;
          end
        end
      endcase
      if (!accessAllowed) begin
        swState <= dpsa_pkg::SW_IDLE;
      end
    end
  end
  assign singleWireOutEnable = (swState == dpsa_pkg::SW_PRESENCE);
  logic swActivates;
  assign swActivates = (swState == dpsa_pkg::SW_ARMED) & swFall;

  // ************************************************
  // Arbiter
  // ************************************************
  dpsa_pkg::dpsa_grant_t grantState;
  always_ff @(posedge clock) begin
    if (reset) begin
      grantState <= dpsa_pkg::GRANT_NONE;
    end else if (clockEnable) begin
      case (grantState)
        dpsa_pkg::GRANT_NONE: begin
          if (accessAllowed && selRise && swEnabled) grantState <= dpsa_pkg::GRANT_THREE;
          else if (accessAllowed && swActivates) grantState <= dpsa_pkg::GRANT_SINGLE;
        end
        dpsa_pkg::GRANT_THREE: if (selFall || !accessAllowed) grantState <= dpsa_pkg::GRANT_NONE;
        dpsa_pkg::GRANT_SINGLE: begin
          // Held through every slot; only the closing reset pulse or loss of accessAllowed leaves the busy state
          if (swState != dpsa_pkg::SW_BUSY || !accessAllowed) grantState <= dpsa_pkg::GRANT_NONE;
        end
        default: grantState <= dpsa_pkg::GRANT_NONE;
      endcase
    end
  end
  assign grant = grantState;
  logic threeOwns;
  assign threeOwns = (grantState == dpsa_pkg::GRANT_THREE) & sel;
  assign singleWireGranted = (grantState == dpsa_pkg::GRANT_SINGLE);
  // Denied single-wire: reads float high, so every returned bit is one
  assign singleWireDenied = (grantState == dpsa_pkg::GRANT_THREE) & (swState == dpsa_pkg::SW_BUSY);
  assign eventCountPulse = threeWireOnly & accessAllowed & swFall & (grantState != dpsa_pkg::GRANT_SINGLE);

  // ************************************************
  // Three-wire shifter
  // ************************************************
  logic [`DPSA_BIT_W-1:0] bitIndex;
  logic [`DPSA_BYTE_W-1:0] shiftIn, shiftOut;
  logic haveFirst, outBit, driving;
  always_ff @(posedge clock) begin
    if (reset) begin
      bitIndex <= '0;
      shiftIn <= 8'h00;
      shiftOut <= 8'h00;
      rxByte <= 8'h00;
      rxByteValid <= 1'b0;
      rxFirst <= 1'b0;
      txByteTaken <= 1'b0;
      transferEnd <= 1'b0;
      haveFirst <= 1'b0;
      outBit <= 1'b0;
      driving <= 1'b0;
    end else if (clockEnable) begin
      rxByteValid <= 1'b0;
      txByteTaken <= 1'b0;
      transferEnd <= selFall & (grantState == dpsa_pkg::GRANT_THREE);
      if (!threeOwns) begin
        bitIndex <= '0;
        shiftIn <= 8'h00;
        haveFirst <= 1'b0;
        driving <= 1'b0;
      end else if (sclkRise) begin
        shiftIn <= {dqIn, shiftIn[7:1]};
        bitIndex <= bitIndex + `DPSA_BIT_W'(1);
        if (bitIndex == `DPSA_BIT_W'(7)) begin
          rxByte <= {dqIn, shiftIn[7:1]};
          rxByteValid <= ~txReading;
          rxFirst <= ~haveFirst;
          haveFirst <= 1'b1;
        end
      end else if (sclkFall && txReading) begin
        // Load a fresh byte at each byte boundary, then shift LSB first
        if (bitIndex == `DPSA_BIT_W'(0)) begin
          outBit <= txByte[0];
          shiftOut <= {1'b0, txByte[7:1]};
          txByteTaken <= 1'b1;
        end else begin
          outBit <= shiftOut[0];
          shiftOut <= {1'b0, shiftOut[7:1]};
        end
        driving <= 1'b1;
      end else if (sclk) begin
        driving <= 1'b0;
      end
    end
  end
  assign dataOut = outBit;
  // Gate with live synchronised levels so release needs no extra cycle
  assign dataOutEnable = driving & threeOwns & ~sclk & txReading;
endmodule : dpsa_arbiter
`default_nettype wire

// *** inc/dpsa_consts.svh ***
// Constants for the dual-port serial arbiter: timing counts and widths.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef DPSA_CONSTS_SVH
`define DPSA_CONSTS_SVH
`define DPSA_CLK_MHZ 200
`define DPSA_SETTLE_MS 123
`define DPSA_SETTLE_TOL_MS 2
// Settle count: nominal time in cycles, inside the tolerance band
`define DPSA_SETTLE_CYC (`DPSA_SETTLE_MS * 1000 * `DPSA_CLK_MHZ)
`define DPSA_PDH_US 30
`define DPSA_PDH_CYC (`DPSA_PDH_US * `DPSA_CLK_MHZ)
`define DPSA_PDL_US 120
`define DPSA_PDL_CYC (`DPSA_PDL_US * `DPSA_CLK_MHZ)
`define DPSA_RSTL_US 480
// Least reset low time, rounded up to cycles
`define DPSA_RSTL_CYC (`DPSA_RSTL_US * `DPSA_CLK_MHZ)
`define DPSA_CNT_W 25
`define DPSA_BYTE_W 8
`define DPSA_BIT_W 3
`endif

// *** inc/dpsa_pkg.sv ***
// Types for the dual-port serial arbiter.
// Assumes nothing beyond a SystemVerilog compiler.
package dpsa_pkg;
  typedef enum logic [1:0] {GRANT_NONE, GRANT_THREE, GRANT_SINGLE} dpsa_grant_t;
  typedef enum logic [2:0] {SW_IDLE, SW_RESET_LOW, SW_WAIT_HIGH, SW_PRESENCE, SW_ARMED, SW_BUSY} dpsa_sw_t;
endpackage : dpsa_pkg

// *** verif/dpsa_host_model.sv ***
// Host model: three-wire host and single-wire master.
// Assumes the bench overlaps tasks only where they drive separate lines, as xfer and swSlot do.
`timescale 1ns/1ps
`default_nettype none
module dpsa_host_model (
  output logic selectPin,
  output logic serialClockPin,
  output logic dataIn,
  input wire logic dataOut,
  input wire logic dataOutEnable,
  output logic singleWireIn,
  input wire logic singleWireOutEnable
);
  logic hostDrive = 1'b0;
  logic hostBit = 1'b0;
  logic swLow = 1'b0;
  // Weak pulldown wins on a released data line
  assign dataIn = dataOutEnable ? dataOut : (hostDrive ? hostBit : 1'b0);
  assign singleWireIn = !(swLow || singleWireOutEnable);
  initial begin
    selectPin = 1'b0;
    serialClockPin = 1'b0;
  end
  task automatic swReset(input int lowNs);
    swLow = 1'b1;
    #(lowNs);
    swLow = 1'b0;
    // Presence is over 150 us after release
    #170000;
  endtask : swReset
  task automatic swSlot(input int lowNs);
    swLow = 1'b1;
    #(lowNs);
    swLow = 1'b0;
    #500;
  endtask : swSlot
  // Quiet wait and scratch token handshake belong to firmware above this model
  // Bits from rdFrom on are read: one sample per clock cycle, taken at the end of clock low
  task automatic xfer(input logic [7:0] wr, input int n, input int rdFrom, output logic [7:0] rd);
    rd = 8'h00;
    selectPin = 1'b1;
    #1000;
    for (int i = 0; i < n; i++) begin
      hostDrive = (i < rdFrom);
      hostBit = wr[i[2:0]];
      #24;
      rd = {dataIn, rd[7:1]};
      serialClockPin = 1'b1;
      #24;
      serialClockPin = 1'b0;
    end
    hostDrive = 1'b0;
    #100;
    selectPin = 1'b0;
    #1000;
  endtask : xfer
endmodule : dpsa_host_model
`default_nettype wire

// *** verif/dpsa_arbiter_assertions.sv ***
// Port checker for dpsa_arbiter.
// Assumes one clock domain; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module dpsa_arbiter_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic selectPin,
  input wire logic serialClockPin,
  input wire logic dataOutEnable,
  input wire logic [1:0] grant,
  input wire logic accessAllowed,
  input wire logic singleWireGranted,
  input wire logic rxByteValid,
  input wire logic transferEnd
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  chk_clk_high_float: assert property (serialClockPin [*4] |-> !dataOutEnable)
    else $error("data line driven while serial clock high");
  chk_desel_float: assert property (!selectPin [*4] |-> !dataOutEnable)
    else $error("data line driven while deselected");
  chk_sw_grant_float: assert property (singleWireGranted |-> !dataOutEnable && grant == 2'h2)
    else $error("data line driven under single-wire grant");
  chk_no_supply_float: assert property (!accessAllowed |=> !dataOutEnable && grant != 2'h1)
    else $error("three-wire access without supply margin");
  chk_grant_hold: assert property (selectPin [*4] ##0 grant == 2'h1 && accessAllowed |=> grant == 2'h1)
    else $error("three-wire grant lost mid transfer");
  chk_three_start: assert property ($past(grant) == 2'h0 && grant == 2'h1 |-> $past(selectPin, 2))
    else $error("three-wire grant without select rise");
  chk_end_after_fall: assert property (transferEnd |-> !$past(selectPin, 2))
    else $error("transfer end without select fall");
  chk_launch_clk_low: assert property ($rose(dataOutEnable) |-> !$past(serialClockPin, 2))
    else $error("read bit launched while clock high");
  chk_rx_pulse: assert property (rxByteValid |=> !rxByteValid)
    else $error("byte strobe longer than one cycle");
  cov_byte: cover property (rxByteValid);
  cov_read: cover property ($rose(dataOutEnable));
  cov_end: cover property (transferEnd);
  cov_sw_grant: cover property (singleWireGranted);
endmodule : dpsa_arbiter_assertions
bind dpsa_arbiter dpsa_arbiter_assertions chk (
  .clock(clock), .reset(reset), .selectPin(selectPin), .serialClockPin(serialClockPin),
  .dataOutEnable(dataOutEnable), .grant(grant), .accessAllowed(accessAllowed),
  .singleWireGranted(singleWireGranted), .rxByteValid(rxByteValid), .transferEnd(transferEnd));
`default_nettype wire

// *** verif/dpsa_arbiter_tb_top.sv ***
// Self-checking bench for dpsa_arbiter.
// Assumes the host model drives both ports.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module dpsa_arbiter_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic supplyMarginOk = 1'b1;
  logic threeWireOnly = 1'b0;
  logic txReading = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rd;
  logic [7:0] gotByte;
  logic gotFirst;
  wire logic selectPin, serialClockPin, dataIn, dataOut, dataOutEnable, singleWireIn, singleWireOutEnable;
  wire logic rxByteValid, rxFirst, transferEnd, accessAllowed, eventCountPulse;
  wire logic singleWireGranted, singleWireDenied, txByteTaken;
  wire logic [7:0] rxByte;
  wire logic [1:0] grant;
  int errCount = 0;
  int comparisons = 0;
  int gotCnt = 0;
  int presCnt = 0;
  int evCnt = 0;
  int cycles = 0;
  int tkCnt = 0;
  int endCnt = 0;
  int n0;
  int n1;
  initial begin
    forever #2.5 clock = ~clock;
  end
  dpsa_host_model host (.selectPin(selectPin), .serialClockPin(serialClockPin), .dataIn(dataIn),
    .dataOut(dataOut), .dataOutEnable(dataOutEnable), .singleWireIn(singleWireIn),
    .singleWireOutEnable(singleWireOutEnable));
  dpsa_arbiter DUT (.clock(clock), .reset(reset), .clockEnable(1'b1), .selectPin(selectPin),
    .serialClockPin(serialClockPin), .dataIn(dataIn), .dataOut(dataOut), .dataOutEnable(dataOutEnable),
    .singleWireIn(singleWireIn), .singleWireOutEnable(singleWireOutEnable), .supplyMarginOk(supplyMarginOk),
    .oscillatorRunning(1'b0), .threeWireOnly(threeWireOnly), .rxByteValid(rxByteValid), .rxByte(rxByte),
    .rxFirst(rxFirst), .txByte(txByte), .txReading(txReading), .txByteTaken(txByteTaken),
    .transferEnd(transferEnd), .grant(grant), .accessAllowed(accessAllowed),
    .singleWireGranted(singleWireGranted), .singleWireDenied(singleWireDenied),
    .eventCountPulse(eventCountPulse));
  // Ceiling leaves room over the two long line resets
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rxByteValid === 1'b1) begin
      gotCnt <= gotCnt + 1;
      gotByte <= rxByte;
      gotFirst <= rxFirst;
    end
    if (singleWireOutEnable === 1'b1) presCnt <= presCnt + 1;
    if (eventCountPulse === 1'b1) evCnt <= evCnt + 1;
    if (txByteTaken === 1'b1) tkCnt <= tkCnt + 1;
    if (transferEnd === 1'b1) endCnt <= endCnt + 1;
    if (cycles == 300000) begin
      errCount++;
      results();
    end
  end
  task automatic waitEdges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : waitEdges
  task automatic results;
    if (errCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  task automatic testPresence;
    host.swReset(490000);
    `CHK(presCnt >= 12000 && presCnt <= 48000, 1'b1)
    `CHK(grant, 2'h0)
  endtask : testPresence
  task automatic testWrite;
    n0 = gotCnt;
    n1 = endCnt;
    host.xfer(8'h3c, 8, 8, rd);
    `CHK(gotCnt, n0 + 1)
    `CHK({gotFirst, gotByte}, 9'h13c)
    `CHK(endCnt, n1 + 1)
  endtask : testWrite
  // Command byte first; read phase starts at the fall after its last rise
  task automatic testRead;
    txByte = 8'ha5;
    n1 = tkCnt;
    fork
      host.xfer(8'hc1, 16, 8, rd);
      begin
        @(posedge clock iff rxByteValid === 1'b1);
        #1;
        txReading = 1'b1;
      end
    join
    txReading = 1'b0;
    `CHK(gotByte, 8'hc1)
    `CHK(rd, 8'ha5)
    `CHK(tkCnt, n1 + 2)
  endtask : testRead
  task automatic testAbort;
    n0 = gotCnt;
    host.xfer(8'hff, 3, 3, rd);
    `CHK(gotCnt, n0)
  endtask : testAbort
  task automatic testSingle;
    host.swSlot(500);
    `CHK(grant, 2'h2)
    `CHK(singleWireGranted, 1'b1)
    n0 = gotCnt;
    host.xfer(8'h5a, 8, 8, rd);
    `CHK(gotCnt, n0)
    txReading = 1'b1;
    host.xfer(8'h00, 16, 0, rd);
    txReading = 1'b0;
    `CHK(rd, 8'h00)
    `CHK(grant, 2'h2)
    host.swReset(490000);
    `CHK(grant, 2'h0)
  endtask : testSingle
  task automatic testCross;
    n0 = gotCnt;
    fork
      host.xfer(8'h96, 8, 8, rd);
      begin
        #1050;
        host.swSlot(200);
      end
      begin
        #1150;
        `CHK(grant, 2'h1)
        `CHK(singleWireDenied, 1'b1)
      end
    join
    `CHK(gotCnt, n0 + 1)
    `CHK(gotByte, 8'h96)
  endtask : testCross
  task automatic testSupply;
    supplyMarginOk = 1'b0;
    waitEdges(2);
    `CHK(accessAllowed, 1'b0)
    n0 = gotCnt;
    host.xfer(8'h55, 8, 8, rd);
    `CHK(gotCnt, n0)
    supplyMarginOk = 1'b1;
    waitEdges(3);
    `CHK(accessAllowed, 1'b1)
  endtask : testSupply
  task automatic testCounter;
    threeWireOnly = 1'b1;
    n0 = evCnt;
    repeat (3) host.swSlot(500);
    `CHK(evCnt - n0, 3)
  endtask : testCounter
  initial begin
    waitEdges(6);
    reset = 1'b0;
    waitEdges(2);
    testPresence();
    testWrite();
    testRead();
    testAbort();
    testSingle();
    testCross();
    testSupply();
    testCounter();
    results();
  end
endmodule : dpsa_arbiter_tb_top
`default_nettype wire
